/* File: hw/instr_timing_pkg.sv */
// Package with opcode encodings, lengths, cycle counts and carrier types.
package instr_timing_pkg;
    localparam int unsigned OPCODE_W = 8;
    localparam int unsigned LEN_W = 2;
    localparam int unsigned CYC_W = 4;
    localparam logic [CYC_W-1:0] MAX_CYCLES = 4'h8;
    localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 2'h3;
    localparam logic [CYC_W-1:0] CYC_1 = 4'h1;
    localparam logic [CYC_W-1:0] CYC_2 = 4'h2;
    localparam logic [CYC_W-1:0] CYC_3 = 4'h3;
    localparam logic [CYC_W-1:0] CYC_4 = 4'h4;
    // Group encodings in the upper nibble of the first opcode byte.
    localparam logic [3:0] GRP_INC = 4'h0;
    localparam logic [3:0] GRP_DEC = 4'h1;
    localparam logic [3:0] GRP_ADD = 4'h2;
    localparam logic [3:0] GRP_ADD_WITH_CARRY = 4'h3;
    localparam logic [3:0] GRP_ORL = 4'h4;
    localparam logic [3:0] GRP_ANL = 4'h5;
    localparam logic [3:0] GRP_XRL = 4'h6;
    localparam logic [3:0] GRP_MOVI = 4'h7;
    localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;
    localparam logic [3:0] GRP_MOVRD = 4'ha;
    localparam logic [3:0] GRP_XCH = 4'hc;
    localparam logic [3:0] GRP_MOVA = 4'he;
    localparam logic [3:0] GRP_MOVW = 4'hf;
    localparam logic [3:0] GRP_MOVDR = 4'h8;
    // Whole opcodes with their own timing.
    localparam logic [7:0] OP_RRC = 8'h13;
    localparam logic [7:0] OP_RLC = 8'h33;
    localparam logic [7:0] OP_ORL_DI = 8'h43;
    localparam logic [7:0] OP_ANL_DI = 8'h53;
    localparam logic [7:0] OP_XRL_DI = 8'h63;
    localparam logic [7:0] OP_CODE_MEMORY_READ_PC = 8'h83;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [7:0] OP_MOV_DD = 8'h85;
    localparam logic [7:0] OP_MOV_DPI = 8'h90;
    localparam logic [7:0] OP_CODE_MEMORY_READ_DP = 8'h93;
    localparam logic [7:0] OP_INC_DP = 8'ha3;
    localparam logic [7:0] OP_MUL = 8'ha4;
    localparam logic [7:0] OP_PUSH = 8'hc0;
    localparam logic [7:0] OP_POP = 8'hd0;
    localparam logic [7:0] OP_NIB_XCH0 = 8'hd6;
    localparam logic [7:0] OP_NIB_XCH1 = 8'hd7;
    localparam logic [7:0] OP_CPL_A = 8'hf4;
    localparam logic [7:0] OP_XMOV_RD_DP = 8'he0;
    localparam logic [7:0] OP_XMOV_WR_DP = 8'hf0;
    localparam logic [7:0] OP_NOP = 8'h00;

    typedef struct packed {
        logic [LEN_W-1:0] length;
        logic [CYC_W-1:0] cycles;
        logic bank_reg;
        logic indirect;
        logic ext_move;
        logic ext_write;
        logic [2:0] reg_sel;
    } decode_t;

    typedef struct packed {
        logic valid;
        logic [OPCODE_W-1:0] opcode;
    } fetch_t;

    typedef struct packed {
        logic ext_move;
        logic ext_write;
        logic flash_sel;
        logic [4:0] bank_index;
    } exec_t;
endpackage : instr_timing_pkg

/* File: hw/opcode_length_table.sv */
// Combinational lookup of byte length and cycle count from the first byte.
`timescale 1ns/100ps
`default_nettype none
module opcode_length_table (
    // Opcode in
    input wire logic [instr_timing_pkg::OPCODE_W-1:0] opcode,
    // Decoded attributes
    output var instr_timing_pkg::decode_t info
);
    import instr_timing_pkg::*;

    wire [3:0] grp = opcode[7:4];
    wire [3:0] low = opcode[3:0];
    wire is_bank = opcode[3];
    wire is_ind = (low[3:1] == 3'h3);
    wire is_imm = (low == 4'h4);
    wire is_dir = (low == 4'h5);
    wire is_arith = (grp == GRP_ADD) || (grp == GRP_ADD_WITH_CARRY) || (grp == GRP_SUBTRACT_WITH_BORROW);
    wire is_logic = (grp == GRP_ORL) || (grp == GRP_ANL) || (grp == GRP_XRL);
    wire is_xmov = (grp >= GRP_MOVA) && (low[3:2] == 2'h0)
        && (low[1:0] != 2'h1);

    always_comb begin
        info = '0;
        info.length = LEN_1;
        info.cycles = CYC_1;
        info.bank_reg = is_bank;
        info.indirect = is_ind;
        info.reg_sel = is_bank ? opcode[2:0] : {2'h0, opcode[0]};
        info.ext_move = is_xmov;
        info.ext_write = is_xmov && (grp == GRP_MOVW);
        if (opcode == OP_DIV) begin
            info.cycles = MAX_CYCLES;
        end else if (opcode == OP_MUL) begin
            info.cycles = CYC_4;
        end else if (opcode == OP_ANL_DI || opcode == OP_ORL_DI
                || opcode == OP_XRL_DI || opcode == OP_MOV_DD
                || opcode == OP_MOV_DPI) begin
            info.length = LEN_3;
            info.cycles = CYC_3;
        end else if (opcode == OP_CODE_MEMORY_READ_DP || opcode == OP_CODE_MEMORY_READ_PC) begin
            info.cycles = CYC_3;
        end else if (is_xmov) begin
            info.cycles = CYC_3;
        end else if (opcode == OP_PUSH || opcode == OP_POP) begin
            info.length = LEN_2;
            info.cycles = CYC_2;
        end else if (opcode == OP_NIB_XCH0 || opcode == OP_NIB_XCH1) begin
            info.cycles = CYC_2;
        end else if (opcode == OP_CPL_A) begin
            info.cycles = CYC_2;
        end else if (opcode == OP_RLC || opcode == OP_RRC
                || opcode == OP_INC_DP || opcode == OP_NOP) begin
            info.cycles = CYC_1;
        end else if (is_arith || is_logic || grp == GRP_INC
                || grp == GRP_DEC || grp == GRP_XCH || grp == GRP_MOVA) begin
            if (is_bank) begin
                info.cycles = CYC_1;
            end else if (is_ind) begin
                info.cycles = CYC_2;
            end else if (is_imm && grp != GRP_INC && grp != GRP_DEC
                    && grp != GRP_XCH && grp != GRP_MOVA) begin
                info.length = LEN_2;
                info.cycles = CYC_2;
            end else if (is_dir) begin
                info.length = LEN_2;
                info.cycles = CYC_2;
            end
        end else if (grp == GRP_MOVI && is_ind) begin
            info.length = LEN_2;
            info.cycles = CYC_2;
        end else if ((grp == GRP_MOVI || grp == GRP_MOVRD
                || grp == GRP_MOVDR) && (is_bank || is_ind)) begin
            info.length = LEN_2;
            info.cycles = CYC_2;
        end
    end
endmodule : opcode_length_table
`default_nettype wire

/* File: hw/instr_timing_core.sv */
// Instruction timing sequencer: decodes, stalls fetch, routes external moves.
`timescale 1ns/100ps
`default_nettype none
module instr_timing_core (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fetch side
    input wire instr_timing_pkg::fetch_t fetch_in,
    output logic fetch_ready,
    // Bank select and flash steering
    input wire logic [1:0] bank_select,
    input wire logic flash_write_enable,
    // Execute side
    output logic issue_valid,
    output logic [instr_timing_pkg::LEN_W-1:0] issue_length,
    output logic [instr_timing_pkg::CYC_W-1:0] issue_cycles,
    output var instr_timing_pkg::exec_t issue_exec,
    output logic issue_done
);
    import instr_timing_pkg::*;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } state_t;

    decode_t dec;
    state_t state_reg;
    state_t state_next;
    logic [CYC_W-1:0] count_reg;
    logic [CYC_W-1:0] count_next;

    opcode_length_table u_table (
        .opcode(fetch_in.opcode),
        .info(dec)
    );

    wire accept = fetch_in.valid && fetch_ready;
    wire last_cycle = (count_next == CYC_1);
    // A register operand is the bank base plus the three select bits.
    wire [4:0] bank_index = {bank_select, dec.reg_sel};
    // Flash is reached only by writes, so that reads keep seeing xdata.
    wire flash_sel = dec.ext_move && dec.ext_write && flash_write_enable;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    count_next = dec.cycles;
                    state_next = (dec.cycles > CYC_1) ? ST_BUSY : ST_IDLE;
                end
            end
            ST_BUSY: begin
                count_next = count_reg - CYC_1;
                if (count_next == CYC_1) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Fetch is held while a multi-cycle instruction runs.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_ready <= 1'b0;
        end else begin
            fetch_ready <= (state_next == ST_IDLE);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            issue_valid <= 1'b0;
            issue_length <= '0;
            issue_cycles <= '0;
            issue_exec <= '0;
        end else begin
            issue_valid <= accept;
            if (accept) begin
                issue_length <= dec.length;
                issue_cycles <= dec.cycles;
                issue_exec.ext_move <= dec.ext_move;
                issue_exec.ext_write <= dec.ext_write;
                issue_exec.flash_sel <= flash_sel;
                issue_exec.bank_index <= bank_index;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            issue_done <= 1'b0;
        end else begin
            issue_done <= (state_reg == ST_BUSY && last_cycle)
                || (state_reg == ST_IDLE && accept && dec.cycles == CYC_1);
        end
    end

    // Cycle budget never exceeds the upper bound.
    max_cycles_a: assert property (@(posedge clk) disable iff (!resetn)
        issue_valid |-> (issue_cycles <= MAX_CYCLES && issue_cycles >= CYC_1))
        else $error("cycle count out of range");

    stall_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        (issue_valid && issue_cycles == CYC_3)
        |-> !fetch_ready ##1 !fetch_ready ##1 fetch_ready)
        else $error("fetch not stalled for three cycle instruction");

    single_ready_a: assert property (@(posedge clk) disable iff (!resetn)
        (issue_valid && issue_cycles == CYC_1) |-> fetch_ready)
        else $error("one cycle instruction stalled fetch");

    done_time_a: assert property (@(posedge clk) disable iff (!resetn)
        (issue_valid && issue_cycles == CYC_2) |-> ##1 issue_done)
        else $error("two cycle instruction not done on time");

    flash_route_a: assert property (@(posedge clk) disable iff (!resetn)
        issue_exec.flash_sel |-> issue_exec.ext_write)
        else $error("flash selected without external write");

    xmov_len_a: assert property (@(posedge clk) disable iff (!resetn)
        (issue_valid && issue_exec.ext_move) |->
        (issue_length == LEN_1 && issue_cycles == CYC_3))
        else $error("external move timing wrong");

    bank_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        accept && dec.bank_reg |=> issue_exec.bank_index[4:3] == $past(bank_select))
        else $error("bank index does not follow bank select");

    len_bound_a: assert property (@(posedge clk) disable iff (!resetn)
        (issue_valid && issue_length == LEN_3) |-> issue_cycles == CYC_3)
        else $error("three byte instruction not three cycles");

    issue_only_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == ST_BUSY |-> !accept)
        else $error("instruction accepted while busy");

    cover_single_c: cover property (@(posedge clk) disable iff (!resetn)
        issue_valid && issue_cycles == CYC_1);
    cover_three_c: cover property (@(posedge clk) disable iff (!resetn)
        issue_valid && issue_length == LEN_3);
    cover_flash_c: cover property (@(posedge clk) disable iff (!resetn)
        issue_exec.flash_sel);
    cover_div_c: cover property (@(posedge clk) disable iff (!resetn)
        issue_valid && issue_cycles == MAX_CYCLES);
endmodule : instr_timing_core
`default_nettype wire

/* File: verif/fetch_model.sv */
// Fetch-side partner that presents one opcode and holds it until taken.
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bench request
    input wire logic load,
    input wire logic [7:0] load_opcode,
    input wire logic [3:0] delay,
    // Core side
    input wire logic fetch_ready,
    output var instr_timing_pkg::fetch_t fetch_in
);
    import instr_timing_pkg::*;
    logic pend_reg;
    logic [3:0] wait_reg;
    logic [7:0] op_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_in <= '0;
            pend_reg <= 1'b0;
            wait_reg <= 4'h0;
            op_reg <= 8'h00;
        end else if (fetch_in.valid && fetch_ready) begin
            // A released byte is inverted so a stale opcode never looks live.
            fetch_in.valid <= 1'b0;
            fetch_in.opcode <= ~fetch_in.opcode;
        end else if (load) begin
            pend_reg <= 1'b1;
            wait_reg <= delay;
            op_reg <= load_opcode;
        end else if (pend_reg && wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end else if (pend_reg) begin
            fetch_in <= {1'b1, op_reg};
            pend_reg <= 1'b0;
        end
    end
endmodule : fetch_model
`default_nettype wire

/* File: verif/mcu_core_instr_length_timing_tb_top.sv */
// Self-checking bench for the instruction length and timing core.
`timescale 1ns/100ps
`default_nettype none
module mcu_core_instr_length_timing_tb_top;
    import instr_timing_pkg::*;
    logic clk;
    logic resetn;
    logic load;
    logic [7:0] load_opcode;
    logic [3:0] delay;
    logic [1:0] bank_select;
    logic flash_write_enable;
    fetch_t fetch_in;
    logic fetch_ready;
    logic issue_valid;
    logic [LEN_W-1:0] issue_length;
    logic [CYC_W-1:0] issue_cycles;
    exec_t issue_exec;
    logic issue_done;
    int fail_count = 0;
    int comparisons = 0;

    fetch_model u_fetch (.clk(clk), .resetn(resetn), .load(load),
        .load_opcode(load_opcode), .delay(delay),
        .fetch_ready(fetch_ready), .fetch_in(fetch_in));
    instr_timing_core u_dut (.clk(clk), .resetn(resetn),
        .fetch_in(fetch_in), .fetch_ready(fetch_ready),
        .bank_select(bank_select), .flash_write_enable(flash_write_enable),
        .issue_valid(issue_valid), .issue_length(issue_length),
        .issue_cycles(issue_cycles), .issue_exec(issue_exec),
        .issue_done(issue_done));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, e, g);
        end
    endtask : chk

    // Issues one opcode, then checks length, count, stall and finish time.
    task automatic run_op(input logic [7:0] op, input logic [1:0] len,
                          input logic [3:0] cyc);
        int n;
        logic [3:0] seen;
        n = 0;
        @(posedge clk);
        load <= 1'b1;
        load_opcode <= op;
        @(posedge clk);
        load <= 1'b0;
        while (issue_valid !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 40) begin
                chk("issue_valid", 8'h01, 8'h00);
                print_verdict();
            end
        end
        chk("issue_length", {6'h00, len}, {6'h00, issue_length});
        chk("issue_cycles", {4'h0, cyc}, {4'h0, issue_cycles});
        seen = 4'h1;
        while (issue_done !== 1'b1 && seen < 4'hc) begin
            chk("fetch_ready_stall", 8'h00, {7'h00, fetch_ready});
            @(posedge clk);
            #1;
            seen++;
        end
        chk("done_cycles", {4'h0, cyc}, {4'h0, seen});
        chk("fetch_ready_done", 8'h01, {7'h00, fetch_ready});
    endtask : run_op

    task automatic check_arith();
        logic [15:0] t [12] = '{16'h2811, 16'h3811, 16'h9811, 16'h2522,
            16'h3522, 16'h9522, 16'h2612, 16'h3712, 16'h9612, 16'h2422,
            16'h3422, 16'h9422};
        foreach (t[i]) run_op(t[i][15:8], t[i][5:4], t[i][3:0]);
    endtask : check_arith

    task automatic check_logic();
        logic [15:0] t [8] = '{16'h4333, 16'h5333, 16'h6333, 16'h4612,
            16'h5712, 16'h6612, 16'h3311, 16'h1311};
        delay <= 4'h3;
        foreach (t[i]) run_op(t[i][15:8], t[i][5:4], t[i][3:0]);
        delay <= 4'h0;
    endtask : check_logic

    task automatic check_moves();
        logic [15:0] t [9] = '{16'h8533, 16'h9033, 16'h9313, 16'h8313,
            16'he213, 16'he313, 16'hf013, 16'hc022, 16'hd022};
        foreach (t[i]) run_op(t[i][15:8], t[i][5:4], t[i][3:0]);
    endtask : check_moves

    task automatic check_exchange();
        logic [15:0] t [8] = '{16'hd612, 16'hd712, 16'hc811, 16'hcf11,
            16'h7622, 16'h7722, 16'ha414, 16'h8418};
        foreach (t[i]) run_op(t[i][15:8], t[i][5:4], t[i][3:0]);
    endtask : check_exchange

    task automatic check_bank();
        @(posedge clk);
        bank_select <= 2'h2;
        run_op(8'h2b, 2'h1, 4'h1);
        chk("bank_index", 8'h13, {3'h0, issue_exec.bank_index});
        @(posedge clk);
        bank_select <= 2'h3;
        run_op(8'hcf, 2'h1, 4'h1);
        chk("bank_index", 8'h1f, {3'h0, issue_exec.bank_index});
    endtask : check_bank

    task automatic check_flash();
        @(posedge clk);
        flash_write_enable <= 1'b1;
        run_op(8'hf0, 2'h1, 4'h3);
        chk("exec_flash", 8'h07, {5'h00, issue_exec[7:5]});
        run_op(8'he0, 2'h1, 4'h3);
        chk("exec_read", 8'h04, {5'h00, issue_exec[7:5]});
        @(posedge clk);
        flash_write_enable <= 1'b0;
        run_op(8'hf0, 2'h1, 4'h3);
        chk("exec_xdata", 8'h06, {5'h00, issue_exec[7:5]});
    endtask : check_flash

    task automatic check_reset();
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset_outputs", 8'h00, {fetch_ready, issue_valid, issue_done,
            issue_length, 3'h0});
        chk("reset_exec", 8'h00, issue_exec);
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
        chk("ready_after_reset", 8'h01, {7'h00, fetch_ready});
    endtask : check_reset

    initial begin
        resetn = 1'b0;
        load = 1'b0;
        load_opcode = 8'h00;
        delay = 4'h0;
        bank_select = 2'h0;
        flash_write_enable = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check_arith();
        check_logic();
        check_reset();
        check_moves();
        check_exchange();
        check_bank();
        check_flash();
        print_verdict();
    end
endmodule : mcu_core_instr_length_timing_tb_top
`default_nettype wire
